// ===== hw/ees_defs.svh
// Constants for the two-wire serial memory slave.
`ifndef EES_DEFS_SVH
`define EES_DEFS_SVH
`define EES_DEV_TYPE 4'ha
`define EES_ADDR_W 12
`define EES_PAGE_W 6
`define EES_MEM_BYTES 4096
`define EES_CLK_MHZ 20
`define EES_PROG_MS 5
`define EES_PROG_CYC (`EES_PROG_MS * 1000 * `EES_CLK_MHZ)
`define EES_FIFO_DEPTH 8
`endif

// ===== hw/ees_pkg.sv
// Types shared by the serial memory slave modules.
package ees_pkg;
  typedef enum logic [5:0] {
    EES_IDLE = 6'h01,
    EES_DEVB = 6'h02,
    EES_WRB = 6'h04,
    EES_RDB = 6'h08,
    EES_MACK = 6'h10,
    EES_WAITP = 6'h20
  } ees_state_t;
endpackage

// ===== hw/ees_sync.sv
// Two-flop synchroniser with edge outputs for the bus pins.
`timescale 1ns/1ps
module ees_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic din,
  output logic lvl,
  output logic rise,
  output logic fall
);
  // First stage, read only by the second stage.
  logic meta;
  // Previous synchronised level, for edge finding.
  logic prev;

  // Shift the pin through two stages, then keep one more for edges.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta <= 1'b1;
      lvl <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= din;
      lvl <= meta;
      prev <= lvl;
    end
  end

  assign rise = lvl & ~prev;
  assign fall = ~lvl & prev;
endmodule

// ===== hw/ees_fifo.sv
// Small FIFO holding received page bytes with their in-page address.
`timescale 1ns/1ps
module ees_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Storage words.
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Write side.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level; pointers wrap at DEPTH.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== hw/ees_slave.sv
// Two-wire serial slave in front of a 4096-byte non-volatile array.
//
// Functional notes
// - Start is SDA falling while SCL high.
// - Stop is SDA rising while SCL high.
// - SDA change during SCL high means start/stop.
// - Upper four address bits must match 1010.
// - Address LSB one reads, zero writes.
// - Acknowledge matching address, then read or write.
// - Receiver holds SDA low on ninth clock.
// - In write mode acknowledge every received byte; a data byte is not acked while the staging FIFO is full.
// - Read: release SDA, sample ack, continue or stop.
// - Stop after write starts program, ignores bus.
// - Page write takes 64 bytes, one program cycle.
// - Write increments only low address bits.
// - Over 64 bytes wraps inside the page.
// - No acknowledge while programming; acknowledge after.
// - Address counter holds last access plus one.
// - Counter rolls from 4095 to zero.
// - Master ack sends next byte across array.
// - Silent and inert until a valid start.
// - Program cycle ends within five milliseconds.
// - Reset aborts transfers; running program completes.
`timescale 1ns/1ps
`include "ees_defs.svh"
module ees_slave
  import ees_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = `EES_DEV_TYPE,
  parameter int PROG_CYC = `EES_PROG_CYC,
  parameter int FIFO_DEPTH = `EES_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sup_reset,
  output logic busy
);
  localparam int AW = `EES_ADDR_W;
  localparam int PW = `EES_PAGE_W;
  localparam int FW = PW + 8;

  // ------------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------------
  logic scl, scl_rise, scl_fall;
  logic sda, sda_rise, sda_fall;
  logic rst_s, rst_meta;
  ees_sync u_scl (.clk(clk), .rst_b(rst_b), .din(scl_in), .lvl(scl),
    .rise(scl_rise), .fall(scl_fall));
  ees_sync u_sda (.clk(clk), .rst_b(rst_b), .din(sda_in), .lvl(sda),
    .rise(sda_rise), .fall(sda_fall));

  // The supervisor reset comes from another block; synchronise it too.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_meta <= sup_reset;
      rst_s <= rst_meta;
    end
  end

  // SDA edges while SCL stays high are bus conditions, not data.
  // SCL must already have been high on the sample before: an SDA change
  // made just ahead of an SCL rise lands in the same synchronised cycle
  // and is data setup, not a start or a stop.
  logic start_det, stop_det;
  assign start_det = sda_fall & scl & ~scl_rise;
  assign stop_det = sda_rise & scl & ~scl_rise;

  // ------------------------------------------------------------------
  // Storage and state
  // ------------------------------------------------------------------
  // The array itself; contents are undefined until written.
  logic [7:0] mem [`EES_MEM_BYTES];
  ees_state_t state;
  logic [3:0] bit_cnt; // Counts SCL falls in a byte, 8 is the ack.
  logic [7:0] shreg; // Shift register for both directions.
  logic [AW-1:0] addr; // Address counter.
  logic [1:0] addr_ph; // Which address byte comes next in a write.
  logic wr_any; // A data byte was accepted in this write.
  logic ack_drive; // Device pulls SDA low for an ack.
  logic tx_bit; // Device data bit being sent.
  logic tx_on; // Device is sending data bits.
  logic [$clog2(PROG_CYC+1)-1:0] prog_cnt;
  logic [7:0] rd_byte;

  // Write staging: bytes queue here and drain into the page buffer.
  logic [7:0] page_buf [1 << PW];
  logic [(1<<PW)-1:0] page_vld;
  logic f_in_valid, f_in_ready, f_out_valid;
  logic [FW-1:0] f_out_data;
  logic commit; // Program the page buffer into the array.

  assign rd_byte = mem[addr];

  ees_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk), .rst_b(rst_b),
    .in_valid(f_in_valid), .in_ready(f_in_ready),
    .in_data({addr[PW-1:0], shreg}),
    .out_valid(f_out_valid), .out_ready(!busy),
    .out_data(f_out_data));

  // A data byte is pushed on its ack edge; a full FIFO withholds the ack.
  assign f_in_valid = (state == EES_WRB) && scl_fall && bit_cnt == 4'h8
    && addr_ph == 2'h2 && ack_drive;

  // Only these states follow the bus; the others wait for a start.
  function automatic logic engaged(input ees_state_t s);
    case (s)
      EES_DEVB, EES_WRB, EES_RDB, EES_MACK: engaged = 1'b1;
      default: engaged = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Protocol engine
  // ------------------------------------------------------------------
  // Bits are taken on SCL rise and driven after SCL fall.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= EES_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      addr <= '0;
      addr_ph <= 2'h0;
      wr_any <= 1'b0;
      ack_drive <= 1'b0;
      tx_on <= 1'b0;
      tx_bit <= 1'b1;
      commit <= 1'b0;
    end else begin
      commit <= 1'b0;
      if (rst_s) begin
        // Supervisor reset drops any transfer at once.
        state <= EES_IDLE;
        ack_drive <= 1'b0;
        tx_on <= 1'b0;
        wr_any <= 1'b0;
      end else if (start_det) begin
        // Start or repeated start; write address phase is kept.
        state <= busy ? EES_IDLE : EES_DEVB;
        // The SCL fall that closes the start is not a bit: it wraps to 0.
        bit_cnt <= 4'hf;
        ack_drive <= 1'b0;
        tx_on <= 1'b0;
      end else if (stop_det) begin
        // Closing a write with data launches the program cycle.
        commit <= wr_any;
        wr_any <= 1'b0;
        state <= EES_IDLE;
        ack_drive <= 1'b0;
        tx_on <= 1'b0;
      end else if (engaged(state)) begin
        if (scl_rise) begin
          if (bit_cnt != 4'h8) begin
            shreg <= {shreg[6:0], sda};
          end
          if (state == EES_MACK && bit_cnt == 4'h8) begin
            // Master ack low asks for more, high ends the read.
            state <= sda ? EES_WAITP : EES_RDB;
          end
        end else if (scl_fall) begin
          bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
          ack_drive <= 1'b0;
          if (bit_cnt == 4'h7 && state == EES_DEVB) begin
            if (shreg[7:4] == DEV_TYPE) begin
              ack_drive <= 1'b1;
              if (!shreg[0]) begin
                addr_ph <= 2'h0;
              end
            end else begin
              state <= EES_WAITP;
            end
          end else if (bit_cnt == 4'h7 && state == EES_WRB) begin
            // Every byte of a write is acked unless staging is full.
            ack_drive <= (addr_ph != 2'h2) || f_in_ready;
          end else if (bit_cnt == 4'h7 && state == EES_RDB) begin
            state <= EES_MACK; // Release SDA for the master ack.
            tx_on <= 1'b0;
            addr <= addr + 1'b1;
          end else if (bit_cnt == 4'h8) begin
            if (state == EES_DEVB) begin
              state <= shreg[0] ? EES_RDB : EES_WRB;
              if (shreg[0]) begin
                tx_on <= 1'b1;
                tx_bit <= rd_byte[7];
                shreg <= rd_byte;
              end
            end else if (state == EES_WRB && ack_drive) begin
              if (addr_ph == 2'h0) begin
                // Upper address byte: only four bits reach the array.
                addr[AW-1:8] <= shreg[AW-9:0];
                addr_ph <= 2'h1;
              end else if (addr_ph == 2'h1) begin
                addr[7:0] <= shreg;
                addr_ph <= 2'h2;
              end else begin
                wr_any <= 1'b1;
                addr[PW-1:0] <= addr[PW-1:0] + 1'b1;
                // The page bits above are left as they are.
              end
            end else if (state == EES_RDB) begin
              tx_on <= 1'b1;
              tx_bit <= rd_byte[7];
              shreg <= rd_byte;
            end
          end else if (state == EES_RDB) begin
            // Each SCL rise shifted the register, so the next bit is on top.
            tx_bit <= shreg[7];
          end
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Page buffer and program cycle
  // ------------------------------------------------------------------
  // Later bytes at the same in-page slot replace earlier ones.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      page_vld <= '0;
    end else if (f_out_valid && !busy) begin
      page_buf[f_out_data[FW-1:8]] <= f_out_data[7:0];
      page_vld[f_out_data[FW-1:8]] <= 1'b1;
    end else if (busy && prog_cnt == 1) begin
      page_vld <= '0;
    end else if (rst_s && !busy) begin
      // A write cut short must not leak its bytes into a later page.
      page_vld <= '0;
    end
  end

  // The page-buffer bytes marked valid are written into the array in one step at cycle end.
  always_ff @(posedge clk) begin
    if (busy && prog_cnt == 1) begin
      for (int i = 0; i < (1 << PW); i++) begin
        if (page_vld[i]) begin
          mem[{addr[AW-1:PW], PW'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // Program timer; supervisor reset cannot cut it short.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
      prog_cnt <= '0;
    end else if (commit && !rst_s) begin
      busy <= 1'b1;
      prog_cnt <= ($bits(prog_cnt))'(PROG_CYC);
    end else if (busy) begin
      prog_cnt <= prog_cnt - 1'b1;
      busy <= (prog_cnt != 1);
    end
  end

  // ------------------------------------------------------------------
  // SDA driver, registered; released except for low bits and acks.
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= !rst_s && (ack_drive || (tx_on && !tx_bit));
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  // Each one watches a bus rule right where the logic keeps it.
  ees_a_ack_busy_a: assert property (@(posedge clk) disable iff (!rst_b)
    busy |-> !ack_drive || state == EES_WRB)
    else $error("ack while programming");
  ees_prog_len_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(busy) |-> busy[*8])
    else $error("program cycle too short");
  ees_rst_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    rst_s |=> !sda_oe)
    else $error("driving during reset");
  ees_idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    state == EES_IDLE && $past(state) == EES_IDLE |-> !ack_drive)
    else $error("acting while idle");
  ees_stop_prog_a: assert property (@(posedge clk) disable iff (!rst_b)
    commit && !rst_s |=> busy)
    else $error("stop did not start program");
  ees_bad_dev_a: assert property (@(posedge clk) disable iff (!rst_b)
    state == EES_DEVB && scl_fall && bit_cnt == 4'h7
    && shreg[7:4] != DEV_TYPE |=> !ack_drive)
    else $error("acked foreign address");
  ees_rd_inc_a: assert property (@(posedge clk) disable iff (!rst_b)
    state == EES_RDB && scl_fall && bit_cnt == 4'h7 && !rst_s
    && !start_det && !stop_det |=> addr == $past(addr) + 1'b1)
    else $error("read address not advanced");
  ees_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    start_det && !rst_s && !busy |=> state == EES_DEVB)
    else $error("start not taken");
endmodule

// ===== testbench/ees_master_model.sv
// Behavioural bus master that drives the clock and data lines.
`timescale 1ns/1ps
module ees_master (
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Quarter of the 400 ns bus clock period.
  localparam int Q = 100;
  // Both lines rest high between frames, so the clock stands still.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One clock; data only moves while the clock is low.
  task automatic bit_io(input logic v, output logic s);
    sda_low = ~v;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Start, or repeated start; the extra wait lets an ack end.
  task automatic start();
    sda_low = 1'b0;
    #(2 * Q) scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Stop, leaving the bus idle for the next frame.
  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #(2 * Q);
  endtask
  // Byte out MSB first, then the answer on the ninth clock.
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // Byte in; a low ninth clock asks for more.
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~mack, s);
  endtask
endmodule

// ===== testbench/ees_slave_test.sv
// Self-checking bench for the two-wire serial memory slave.
`timescale 1ns/1ps
module ees_slave_test;
  import ees_pkg::*;
  // Short program cycle, still long enough to poll during it.
  localparam int PROG = 400;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sup_reset = 1'b0;
  logic scl, m_low, sda_out, sda_oe, busy, sda;
  int n_mismatch = 0;
  int checked = 0;
  logic [7:0] ref_mem [0:4095];
  always #25 clk = ~clk;
  // Pulled-up data line: low whenever any party pulls it.
  assign sda = ~(m_low | (sda_oe & ~sda_out));
  ees_slave #(.PROG_CYC(PROG)) ees_slave_inst (.clk(clk), .rst_b(rst_b),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .sup_reset(sup_reset), .busy(busy));
  ees_master ees_master_inst (.sda(sda), .scl(scl), .sda_low(m_low));
  // ----------------------------------------
  // Checking and bus helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] got,
                     input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Start plus device byte with the given direction bit.
  task automatic sel(input logic rd, output logic ack);
    ees_master_inst.start();
    ees_master_inst.wr_byte({4'ha, 3'($urandom), rd}, ack);
  endtask
  // Device byte and both address bytes; upper nibble is junk.
  task automatic set_addr(input logic [11:0] a);
    logic ack;
    sel(1'b0, ack);
    chk("dev ack", 8'(ack), 8'h01);
    ees_master_inst.wr_byte({4'($urandom), a[11:8]}, ack);
    chk("hi ack", 8'(ack), 8'h01);
    ees_master_inst.wr_byte(a[7:0], ack);
    chk("lo ack", 8'(ack), 8'h01);
  endtask
  // Slot of the i-th byte of a page write: the low six bits wrap.
  function automatic logic [11:0] page_slot(input logic [11:0] a,
                                            input int i);
    page_slot = {a[11:6], 6'(a[5:0] + i)};
  endfunction
  // Write n random bytes; the model wraps inside the page.
  task automatic wr_data(input logic [11:0] a, input int n);
    logic ack;
    logic [7:0] d;
    set_addr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      ref_mem[page_slot(a, i)] = d;
      ees_master_inst.wr_byte(d, ack);
      chk("data ack", 8'(ack), 8'h01);
    end
    ees_master_inst.stop();
  endtask
  // Random or current read of n bytes, the last one not acked.
  task automatic rd_data(input logic [11:0] a, input int n,
                         input logic cur);
    logic ack;
    logic [7:0] d;
    if (!cur) begin
      set_addr(a);
    end
    sel(1'b1, ack);
    chk("read ack", 8'(ack), 8'h01);
    for (int i = 0; i < n; i++) begin
      ees_master_inst.rd_byte(i < n - 1, d);
      chk("read data", d, ref_mem[12'(a + i)]);
    end
    ees_master_inst.stop();
  endtask
  // Program cycle must start at the stop and end in time.
  task automatic wait_prog(input logic hold);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("busy rise", 8'(busy), 8'h01);
    sup_reset = hold;
    n = 0;
    while (busy !== 1'b0 && n < PROG + 20) begin
      @(negedge clk);
      n++;
    end
    chk("busy fall", 8'(busy), 8'h00);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int seed;
    logic ack;
    logic [11:0] a;
    seed = $urandom(8);
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk("oe idle", 8'(sda_oe), 8'h00);
    // A device byte with no start in front must be ignored.
    ees_master_inst.wr_byte(8'ha0, ack);
    chk("no start", 8'(ack), 8'h00);
    ees_master_inst.stop();
    // Every type pattern; only the matching one is answered.
    for (int t = 0; t < 16; t++) begin
      ees_master_inst.start();
      ees_master_inst.wr_byte({4'(t), 4'h0}, ack);
      chk("type ack", 8'(ack), 8'(t == 10));
      ees_master_inst.stop();
    end
    $display("test addressing done");
    // Byte write, then a poll that must be refused while busy.
    a = 12'($urandom);
    wr_data(a, 1);
    sel(1'b0, ack);
    chk("poll busy", 8'(ack), 8'h00);
    ees_master_inst.stop();
    wait_prog(1'b0);
    rd_data(a, 1, 1'b0);
    $display("test byte write done");
    // Page write of 66 bytes from offset 62 wraps once and rewrites offsets 62 and 63.
    a = {6'($urandom), 6'h3e};
    wr_data(a, 66);
    wait_prog(1'b0);
    rd_data({a[11:6], 6'h00}, 64, 1'b0);
    rd_data({a[11:6], 6'h05}, 1, 1'b0);
    rd_data({a[11:6], 6'h06}, 1, 1'b1);
    $display("test page write done");
    // Sequential read across the top of the array.
    wr_data(12'hfff, 1);
    wait_prog(1'b0);
    wr_data(12'h000, 1);
    wait_prog(1'b0);
    rd_data(12'hfff, 2, 1'b0);
    $display("test rollover done");
    // Supervisor reset: program completes, bus is refused.
    a = 12'($urandom);
    wr_data(a, 1);
    wait_prog(1'b1);
    sel(1'b0, ack);
    chk("reset refuse", 8'(ack), 8'h00);
    ees_master_inst.stop();
    sup_reset = 1'b0;
    repeat (8) @(negedge clk);
    rd_data(a, 1, 1'b0);
    // A transfer cut by supervisor reset gets no further ack.
    sel(1'b0, ack);
    sup_reset = 1'b1;
    ees_master_inst.wr_byte(8'h00, ack);
    chk("abort ack", 8'(ack), 8'h00);
    ees_master_inst.stop();
    sup_reset = 1'b0;
    $display("test supervisor reset done");
    report_and_stop();
  end
  // Watchdog well beyond the expected run of about 1 ms.
  initial begin
    #3000000;
    n_mismatch++;
    $display("mismatch watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule
